// >>> design/rgb_consts.svh
// Offsets, reset values and widths of the shared and per-module intensity registers.
`ifndef RGB_CONSTS_SVH
`define RGB_CONSTS_SVH

`define RGB_ADDR_W        8
`define RGB_DATA_W        8
`define RGB_LEVEL_W       12
`define RGB_MODULES       6
`define RGB_COLOURS       3

`define RGB_OFS_GRP_INT   8'h04
`define RGB_OFS_GRP_MIX0  8'h05
`define RGB_OFS_GRP_MIX1  8'h06
`define RGB_OFS_GRP_MIX2  8'h07
`define RGB_OFS_MOD0      8'h08
`define RGB_OFS_MOD1      8'h09
`define RGB_OFS_MOD2      8'h0A
`define RGB_OFS_MOD3      8'h0B
`define RGB_OFS_MOD4      8'h0C
`define RGB_OFS_MOD5      8'h0D

`define RGB_RST_INT       8'hFF
`define RGB_RST_MIX       8'h00
`define RGB_RD_UNMAPPED   8'h00

`endif

// >>> design/rgb_pkg.sv
// Types shared by the intensity register bank.
`include "rgb_consts.svh"

package rgb_pkg;

  typedef logic [`RGB_DATA_W-1:0]  rgb_byte_t;
  typedef logic [`RGB_LEVEL_W-1:0] rgb_level_t;

  // Whole state of the register bank, registered once per clock.
  typedef struct packed {
    logic [`RGB_DATA_W-1:0]                                 grp_int;
    logic [`RGB_COLOURS-1:0][`RGB_DATA_W-1:0]               grp_mix;
    logic [`RGB_MODULES-1:0][`RGB_DATA_W-1:0]               mod_int;
    logic [`RGB_DATA_W-1:0]                                 rdata;
    logic                                                   rvalid;
    logic [`RGB_MODULES-1:0][`RGB_LEVEL_W-1:0]              level;
    logic [`RGB_MODULES-1:0][`RGB_COLOURS-1:0][`RGB_DATA_W-1:0] colour;
  } rgb_state_s;

endpackage

// >>> design/rgb_curve.sv
// Dimming curve: maps an 8-bit intensity code to a 12-bit output level.
`timescale 1ns/1ps
`include "rgb_consts.svh"

module rgb_curve
(
  // Code and curve choice.
  input  wire logic [`RGB_DATA_W-1:0]  code_i,
  input  wire logic                    log_i,
  // Scaled level.
  output logic      [`RGB_LEVEL_W-1:0] level_o
);

  logic [15:0] square;

  // The square curve stands in for the logarithmic law; the added 2*code term lifts FFh to
  // exactly FFFh so both curves agree at the end points.
  assign square = 16'(code_i) * 16'(code_i) + {7'h00, code_i, 1'b0};

  // Linear replicates the top nibble so 00h, 80h and FFh land on 0, half and full scale.
  assign level_o = log_i ? square[15:4] : {code_i, code_i[7:4]};

endmodule

// >>> design/rgb_bank_regs.sv
// Shared group and per-module intensity and colour-mix register bank.
`timescale 1ns/1ps
`include "rgb_consts.svh"

// Operation
// - Group intensity register at 04h, read/write, resets to FFh.
// - Intensity code scales output: 00h none, 80h half, FFh full; the log curve gives 410h at 80h.
// - First-colour group mix register at 05h, read/write, resets to 00h.
// - Second-colour group mix register at 06h, read/write, resets to 00h.
// - Third-colour group mix register at 07h, read/write, resets to 00h.
// - Colour mix code sets percentage: 00h zero, 80h half, FFh full.
// - Module 0 intensity register at 08h, read/write, resets to FFh.
// - Module 1 intensity register at 09h, read/write, resets to FFh.
// - Module 2 intensity register at 0Ah, read/write, resets to FFh.
// - Module 3 intensity register at 0Bh, read/write, resets to FFh.
// - Module 4 intensity register at 0Ch, read/write, resets to FFh.
// - Module 5 intensity register at 0Dh, read/write, resets to FFh.
// - Group-select bit set uses group registers; clear uses module's own.
// - Curve select one gives logarithmic dimming, zero gives linear.
module rgb_bank_regs
(
  // Clock and reset.
  input  wire logic                                          clk_i,
  input  wire logic                                          reset_i,
  // Register port from the serial bus decoder.
  input  wire logic                                          wr_en_i,
  input  wire logic                                          rd_en_i,
  input  wire logic [`RGB_ADDR_W-1:0]                        addr_i,
  input  wire logic [`RGB_DATA_W-1:0]                        wdata_i,
  output logic      [`RGB_DATA_W-1:0]                        rdata_o,
  output logic                                               rvalid_o,
  // Mode controls held elsewhere in the device.
  input  wire logic [`RGB_MODULES-1:0]                       module_group_select_i,
  input  wire logic                                          log_curve_i,
  input  wire logic [`RGB_MODULES*`RGB_COLOURS*`RGB_DATA_W-1:0] module_colour_i,
  // Per-module values toward the PWM engine.
  output logic      [`RGB_MODULES*`RGB_LEVEL_W-1:0]          module_level_o,
  output logic      [`RGB_MODULES*`RGB_COLOURS*`RGB_DATA_W-1:0] module_colour_o
);

  rgb_pkg::rgb_state_s r;
  rgb_pkg::rgb_state_s next_r;
  rgb_pkg::rgb_byte_t  src_int [`RGB_MODULES];
  rgb_pkg::rgb_level_t curve_level [`RGB_MODULES];

  ////////////////////////////////////////////////////////////////////////////////
  // Source selection and dimming curve per module.

  // Intensity source follows the group-select bit of each module.
  for (genvar m = 0; m < `RGB_MODULES; m++)
  begin : g_mod
    assign src_int[m] = module_group_select_i[m] ? r.grp_int : r.mod_int[m];

    rgb_curve u_curve
    (
      .code_i  (src_int[m]),
      .log_i   (log_curve_i),
      .level_o (curve_level[m])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: register writes, reads and output staging.

  always_comb
  begin
    next_r        = r;
    next_r.rvalid = 1'b0;
    if (wr_en_i && addr_i == `RGB_OFS_GRP_INT)
      next_r.grp_int = wdata_i;
    if (wr_en_i && addr_i == `RGB_OFS_GRP_MIX0)
      next_r.grp_mix[0] = wdata_i;
    if (wr_en_i && addr_i == `RGB_OFS_GRP_MIX1)
      next_r.grp_mix[1] = wdata_i;
    if (wr_en_i && addr_i == `RGB_OFS_GRP_MIX2)
      next_r.grp_mix[2] = wdata_i;
    for (int m = 0; m < `RGB_MODULES; m++)
    begin
      if (wr_en_i && addr_i == `RGB_OFS_MOD0 + 8'(m))
        next_r.mod_int[m] = wdata_i;
    end
    if (rd_en_i)
    begin
      next_r.rvalid = 1'b1;
      unique case (addr_i)
        `RGB_OFS_GRP_INT:  next_r.rdata = r.grp_int;
        `RGB_OFS_GRP_MIX0: next_r.rdata = r.grp_mix[0];
        `RGB_OFS_GRP_MIX1: next_r.rdata = r.grp_mix[1];
        `RGB_OFS_GRP_MIX2: next_r.rdata = r.grp_mix[2];
        `RGB_OFS_MOD0:     next_r.rdata = r.mod_int[0];
        `RGB_OFS_MOD1:     next_r.rdata = r.mod_int[1];
        `RGB_OFS_MOD2:     next_r.rdata = r.mod_int[2];
        `RGB_OFS_MOD3:     next_r.rdata = r.mod_int[3];
        `RGB_OFS_MOD4:     next_r.rdata = r.mod_int[4];
        `RGB_OFS_MOD5:     next_r.rdata = r.mod_int[5];
        default:           next_r.rdata = `RGB_RD_UNMAPPED;
      endcase
    end
    // Outputs are staged from the current registers, so they trail a write by one clock.
    for (int m = 0; m < `RGB_MODULES; m++)
    begin
      next_r.level[m] = curve_level[m];
      for (int c = 0; c < `RGB_COLOURS; c++)
      begin
        next_r.colour[m][c] = module_group_select_i[m] ? r.grp_mix[c] :
          module_colour_i[(m*`RGB_COLOURS+c)*`RGB_DATA_W +: `RGB_DATA_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset.

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      r         <= '0;
      r.grp_int <= `RGB_RST_INT;
      r.grp_mix <= {`RGB_COLOURS{`RGB_RST_MIX}};
      r.mod_int <= {`RGB_MODULES{`RGB_RST_INT}};
      r.rdata   <= `RGB_RD_UNMAPPED;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Every output is a flip-flop of the state struct.
  assign rdata_o         = r.rdata;
  assign rvalid_o        = r.rvalid;
  assign module_level_o  = r.level;
  assign module_colour_o = r.colour;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and cover points.

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  AST_GRP_INT_RESET: assert property ($past(reset_i) |-> r.grp_int == 8'hFF)
    else $error("Group intensity not FFh after reset.");

  AST_MIX_RESET: assert property ($past(reset_i) |-> r.grp_mix == 24'h000000)
    else $error("Group colour mixes not zero after reset.");

  AST_MOD_RESET: assert property ($past(reset_i) |-> r.mod_int == 48'hFFFFFFFFFFFF)
    else $error("Module intensities not FFh after reset.");

  AST_GRP_INT_WRITE: assert property (
    wr_en_i && addr_i == 8'h04 |=> r.grp_int == $past(wdata_i))
    else $error("Group intensity write lost.");

  AST_MIX_WRITE: assert property (
    wr_en_i && addr_i == 8'h07 |=> r.grp_mix[2] == $past(wdata_i))
    else $error("Third colour mix write lost.");

  AST_MOD5_WRITE: assert property (
    wr_en_i && addr_i == 8'h0D |=> r.mod_int[5] == $past(wdata_i))
    else $error("Module 5 intensity write lost.");

  AST_READ_BACK: assert property (
    rd_en_i && !wr_en_i && addr_i == 8'h09 |=> rvalid_o && rdata_o == $past(r.mod_int[1]))
    else $error("Read of module 1 intensity wrong.");

  AST_READ_NO_EFFECT: assert property (
    rd_en_i && !wr_en_i |=> $stable(r.grp_int) && $stable(r.grp_mix) && $stable(r.mod_int))
    else $error("Read changed a register.");

  AST_LINEAR_LEVEL: assert property (
    !log_curve_i && !module_group_select_i[2] && r.mod_int[2] == 8'h80 |=>
      module_level_o[2*12 +: 12] == 12'h808)
    else $error("Linear half code not at half level.");

  AST_LOG_ENDS: assert property (
    log_curve_i && module_group_select_i[0] && r.grp_int == 8'hFF |=>
      module_level_o[11:0] == 12'hFFF)
    else $error("Log curve full code not at full level.");

  AST_GROUP_COLOUR: assert property (
    module_group_select_i[1] |=> module_colour_o[(1*3+0)*8 +: 8] == $past(r.grp_mix[0]))
    else $error("Grouped module not using group colour mix.");

  AST_OWN_COLOUR: assert property (
    !module_group_select_i[3] |=>
      module_colour_o[(3*3+1)*8 +: 8] == $past(module_colour_i[(3*3+1)*8 +: 8]))
    else $error("Independent module not using its own colour.");

  // First colour mix must take its byte.
  AST_MIX0_WRITE: assert property (
    wr_en_i && addr_i == 8'h05 |=> r.grp_mix[0] == $past(wdata_i))
    else $error("First colour mix write lost.");

  // Second colour mix must take its byte.
  AST_MIX1_WRITE: assert property (
    wr_en_i && addr_i == 8'h06 |=> r.grp_mix[1] == $past(wdata_i))
    else $error("Second colour mix write lost.");

  // Module 0 intensity must take its byte.
  AST_MOD0_WRITE: assert property (
    wr_en_i && addr_i == 8'h08 |=> r.mod_int[0] == $past(wdata_i))
    else $error("Module 0 intensity write lost.");

  // Module 1 intensity must take its byte.
  AST_MOD1_WRITE: assert property (
    wr_en_i && addr_i == 8'h09 |=> r.mod_int[1] == $past(wdata_i))
    else $error("Module 1 intensity write lost.");

  // Module 2 intensity must take its byte.
  AST_MOD2_WRITE: assert property (
    wr_en_i && addr_i == 8'h0A |=> r.mod_int[2] == $past(wdata_i))
    else $error("Module 2 intensity write lost.");

  // Module 3 intensity must take its byte.
  AST_MOD3_WRITE: assert property (
    wr_en_i && addr_i == 8'h0B |=> r.mod_int[3] == $past(wdata_i))
    else $error("Module 3 intensity write lost.");

  // Module 4 intensity must take its byte.
  AST_MOD4_WRITE: assert property (
    wr_en_i && addr_i == 8'h0C |=> r.mod_int[4] == $past(wdata_i))
    else $error("Module 4 intensity write lost.");

  // A group intensity write must not spill into the module registers.
  AST_GRP_WRITE_ISOLATED: assert property (
    wr_en_i && addr_i == 8'h04 |=> $stable(r.mod_int) && $stable(r.grp_mix))
    else $error("Group intensity write disturbed other registers.");

  // A module 0 intensity write must not spill into the group registers.
  AST_MOD_WRITE_ISOLATED: assert property (
    wr_en_i && addr_i == 8'h08 |=> $stable(r.grp_int) && $stable(r.grp_mix))
    else $error("Module write disturbed group registers.");

  // The answer strobe only follows a read.
  AST_RVALID_ONLY_READ: assert property (
    !rd_en_i |=> !rvalid_o)
    else $error("Read answer without a read.");

  // Read data holds between reads so a slow decoder can still pick it up.
  AST_RDATA_HOLD: assert property (
    !rd_en_i |=> $stable(rdata_o))
    else $error("Read data changed without a read.");

  // Unmapped offsets read back as zero.
  AST_UNMAPPED_READ: assert property (
    rd_en_i && (addr_i < 8'h04 || addr_i > 8'h0D) |=> rvalid_o && rdata_o == 8'h00)
    else $error("Unmapped read not zero.");

  // Group intensity read returns the value held before the edge.
  AST_READ_GRP: assert property (
    rd_en_i && addr_i == 8'h04 |=> rdata_o == $past(r.grp_int))
    else $error("Read of group intensity wrong.");

  // First colour mix read returns the held value.
  AST_READ_MIX0: assert property (
    rd_en_i && addr_i == 8'h05 |=> rdata_o == $past(r.grp_mix[0]))
    else $error("Read of first colour mix wrong.");

  // Module 5 intensity read returns the held value.
  AST_READ_MOD5: assert property (
    rd_en_i && addr_i == 8'h0D |=> rdata_o == $past(r.mod_int[5]))
    else $error("Read of module 5 intensity wrong.");

  // Linear zero code gives a dark output.
  AST_LINEAR_ZERO: assert property (
    !log_curve_i && !module_group_select_i[4] && r.mod_int[4] == 8'h00 |=>
      module_level_o[4*12 +: 12] == 12'h000)
    else $error("Linear zero code not dark.");

  // Linear full code gives full scale.
  AST_LINEAR_FULL: assert property (
    !log_curve_i && module_group_select_i[5] && r.grp_int == 8'hFF |=>
      module_level_o[5*12 +: 12] == 12'hFFF)
    else $error("Linear full code not at full level.");

  // Log zero code gives a dark output.
  AST_LOG_ZERO: assert property (
    log_curve_i && !module_group_select_i[1] && r.mod_int[1] == 8'h00 |=>
      module_level_o[1*12 +: 12] == 12'h000)
    else $error("Log zero code not dark.");

  // A grouped module follows the group intensity.
  AST_GROUP_LEVEL: assert property (
    module_group_select_i[0] && !log_curve_i |=>
      module_level_o[11:0] == {$past(r.grp_int), $past(r.grp_int[7:4])})
    else $error("Grouped module not using group intensity.");

  // An independent module follows its own intensity.
  AST_OWN_LEVEL: assert property (
    !module_group_select_i[3] && !log_curve_i |=>
      module_level_o[3*12 +: 12] == {$past(r.mod_int[3]), $past(r.mod_int[3][7:4])})
    else $error("Independent module not using its own intensity.");

  // Third group mix reaches the third colour of a grouped module.
  AST_GROUP_COLOUR_THIRD: assert property (
    module_group_select_i[5] |=> module_colour_o[(5*3+2)*8 +: 8] == $past(r.grp_mix[2]))
    else $error("Grouped module third colour not from group mix.");

  // A full mix code passes through unchanged.
  AST_MIX_FULL_PASS: assert property (
    module_group_select_i[2] && r.grp_mix[1] == 8'hFF |=>
      module_colour_o[(2*3+1)*8 +: 8] == 8'hFF)
    else $error("Full mix code not passed on.");

  COV_WRITE_READ: cover property (wr_en_i && addr_i == 8'h04 ##1 rd_en_i && addr_i == 8'h04);
  COV_GROUP_LOG: cover property (log_curve_i && module_group_select_i == 6'h3F);
  COV_UNMAPPED: cover property (rd_en_i && addr_i == 8'h20);
  COV_OWN_LINEAR: cover property (!log_curve_i && module_group_select_i == 6'h00);
  COV_MOD5_READ: cover property (rd_en_i && addr_i == 8'h0D);

endmodule

// >>> tb/rgb_host_model.sv
// Host model that programs the register bank through its byte strobe port.
`timescale 1ns/1ps

module rgb_host_model
(
  // Clock.
  input  wire logic       clk_i,
  // Strobe port toward the bank.
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  // Read answer.
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle lines start low.
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end

  // Write is taken on the next edge; one idle cycle follows so strobes never merge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o  = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    wdata_o = ~d;
    @(posedge clk_i);
    #1;
  endtask

  // Read answer stands for the one cycle right after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    addr_o  = a;
    rd_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    d       = rdata_i;
    ok      = rvalid_i;
    rd_en_o = 1'b0;
    addr_o  = ~a;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the intensity register bank.
`timescale 1ns/1ps

module tb_top;
  logic         clk_i = 1'b0;
  logic         reset_i = 1'b1;
  logic         wr_en;
  logic         rd_en;
  logic         rvalid;
  logic         ok;
  logic [7:0]   addr;
  logic [7:0]   wdata;
  logic [7:0]   rdata;
  logic [7:0]   got;
  logic [5:0]   sel = 6'h00;
  logic         log_sel = 1'b0;
  logic [143:0] own = '0;
  logic [71:0]  level;
  logic [143:0] colour;
  int           mdl [16];
  int           tbl [3] = '{0, 128, 255};
  int           fail_count = 0;
  int           checks_done = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, host and bank.
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  rgb_host_model i_rgb_host_model (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));

  rgb_bank_regs i_rgb_bank_regs (.clk_i(clk_i), .reset_i(reset_i), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
    .module_group_select_i(sel), .log_curve_i(log_sel), .module_colour_i(own),
    .module_level_o(level), .module_colour_o(colour));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing helpers.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reference curves kept as plain integer arithmetic.
  function automatic int curve(input int c, input bit lg);
    return lg ? ((c * c + 2 * c) >> 4) : (c * 16 + (c >> 4));
  endfunction

  task automatic rd_chk(input int a);
    i_rgb_host_model.rd(8'(a), got, ok);
    chk("rvalid", 16'h0001, {15'h0000, ok});
    chk($sformatf("reg %h", a), 16'(mdl[a]), {8'h00, got});
  endtask

  // Outputs lag a register or input change by one edge; two edges are waited here.
  task automatic out_chk();
    int code;
    repeat (2) @(posedge clk_i);
    #1;
    for (int m = 0; m < 6; m++)
    begin
      code = sel[m] ? mdl[4] : mdl[8 + m];
      chk("level", 16'(curve(code, log_sel)), {4'h0, level[m*12 +: 12]});
      for (int c = 0; c < 3; c++)
        chk("colour", 16'(sel[m] ? mdl[5 + c] : int'(own[(m*3+c)*8 +: 8])),
            {8'h00, colour[(m*3+c)*8 +: 8]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    void'($urandom(32'h9341597A));
    for (int a = 0; a < 16; a++)
      mdl[a] = (a == 4 || (a > 7 && a < 14)) ? 255 : 0;
    repeat (5) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    // Reset values, unmapped neighbours included.
    for (int a = 3; a < 15; a++)
      rd_chk(a);
    out_chk();
    // Random writes to offsets 04h through 0Eh; the unmapped one must be ignored.
    for (int a = 4; a < 15; a++)
    begin
      code_w(a, int'($urandom_range(255)));
    end
    // Reading twice proves reads leave the value alone.
    for (int a = 3; a < 15; a++)
    begin
      rd_chk(a);
      rd_chk(a);
    end
    // Boundary codes under both curves with random grouping and own colours.
    for (int i = 0; i < 12; i++)
    begin
      code_w(4, tbl[i % 3]);
      code_w(5 + i % 3, tbl[(i + 2) % 3]);
      code_w(8 + i % 6, tbl[(i + 1) % 3]);
      sel     = 6'($urandom);
      log_sel = i[0];
      own     = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
      out_chk();
    end
    report_and_stop();
  end

  // Writes update the model only at mapped offsets.
  task automatic code_w(input int a, input int d);
    i_rgb_host_model.wr(8'(a), 8'(d));
    if (a > 3 && a < 14)
      mdl[a] = d;
  endtask

  // Watchdog sized well above the expected run of about two hundred cycles.
  initial
  begin
    #(5 * 4000);
    fail_count++;
    report_and_stop();
  end
endmodule
